// >>> shared/pgp_pkg.sv
// Constants for the port 0 general-purpose pin block.
// Assumes an 8-bit CPU reaching the block through its special function space.
package pgp_pkg;

  // Geometry
  localparam int PORT_W = 8;
  localparam int ADDR_W = 6;

  // Register offsets inside the special function space
  localparam logic [5:0] OFS_OUTPUT_LATCH = 6'h00;
  localparam logic [5:0] OFS_DRIVE_SELECT = 6'h08;
  localparam logic [5:0] OFS_PIN_READBACK = 6'h0b;

  // Values after reset
  localparam logic [7:0] RST_OUTPUT_LATCH = 8'hff;
  localparam logic [7:0] RST_DRIVE_SELECT = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // Answer to a read of an address this block does not own
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

// >>> hdl/pgp_port0.sv
// Port 0 general-purpose pins: output latch, per-bit drive select, pin readback.
// Holds the port storage, the pin output stage control and the read mux.
// Pins have no input latch; software sees the level present at the strobe.
// Assumes the CPU pulses sfrRdStb in the first read state and sfrWrStb in the
// second write state; pins are resolved outside from pinOut and pinOeN.
`timescale 1ns/1ps
module pgp_port0
#(
  parameter int PORT_W = pgp_pkg::PORT_W,
  parameter int ADDR_W = pgp_pkg::ADDR_W
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] sfrAddr,
  input wire logic sfrRdStb,
  input wire logic sfrWrStb,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  output logic sfrRdValid,
  input wire logic [PORT_W-1:0] pinIn,
  input wire logic [PORT_W-1:0] periphOut,
  output logic [PORT_W-1:0] pinOut,
  output logic [PORT_W-1:0] pinOeN
);

  // Data bus is a byte and the map holds the low sixty-four addresses
  initial
  begin
    if (PORT_W < 1 || PORT_W > 8)
      $error("PORT_W must lie between 1 and 8");
    if (ADDR_W != 6)
      $error("ADDR_W must be 6 to cover the special function space");
  end

  logic [PORT_W-1:0] latch_reg;
  logic [PORT_W-1:0] latch_next;
  logic [PORT_W-1:0] driveSel_reg;
  logic [PORT_W-1:0] driveSel_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic rdValid_reg;
  logic [PORT_W-1:0] pinOut_reg;
  logic [PORT_W-1:0] pinOut_next;
  logic [PORT_W-1:0] pinOeN_reg;
  logic [PORT_W-1:0] pinOeN_next;

  // Address decode over the special function space
  wire hitLatch = (sfrAddr == pgp_pkg::OFS_OUTPUT_LATCH);
  wire hitSelect = (sfrAddr == pgp_pkg::OFS_DRIVE_SELECT);
  wire hitReadback = (sfrAddr == pgp_pkg::OFS_PIN_READBACK);
  wire wrLatch = sfrWrStb && hitLatch;
  wire wrSelect = sfrWrStb && hitSelect;
  wire [7:0] latchWide = 8'(latch_reg);
  wire [7:0] selWide = 8'(driveSel_reg);
  wire [7:0] pinWide = 8'(pinIn);

  // Write in the second write state updates the latch or the drive select
  assign latch_next = wrLatch ? sfrWrData[PORT_W-1:0] : latch_reg;
  assign driveSel_next = wrSelect ? sfrWrData[PORT_W-1:0] : driveSel_reg;

  // Readback is read-only: a write there touches nothing
  // Pins are sampled live with no capture latch
  assign rdData_next = !sfrRdStb ? rdData_reg :
                       hitLatch ? latchWide :
                       hitSelect ? selWide :
                       hitReadback ? pinWide :
                       pgp_pkg::UNMAPPED_READ;

  // Per-pin output stage, fed from the next latch value so the pin moves
  // at the same edge as the latch rather than a cycle later
  genvar i;
  generate
    for (i = 0; i < PORT_W; i++)
    begin : gPin
      wire level = latch_next[i] & periphOut[i];
      // Push-pull drives both levels; open drain only sinks
      assign pinOut_next[i] = driveSel_next[i] ? level : 1'b0;
      assign pinOeN_next[i] = driveSel_next[i] ? 1'b0 : level;
    end
  endgenerate

  // Storage registers, reset to latch high and open drain
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      latch_reg <= PORT_W'(pgp_pkg::RST_OUTPUT_LATCH);
      driveSel_reg <= PORT_W'(pgp_pkg::RST_DRIVE_SELECT);
    end
    else
    begin
      latch_reg <= latch_next;
      driveSel_reg <= driveSel_next;
    end
  end

  // Read data and pin drive flops; pins float during reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdData_reg <= pgp_pkg::RST_READ_DATA;
      rdValid_reg <= 1'b0;
      pinOut_reg <= '0;
      pinOeN_reg <= '1;
    end
    else
    begin
      rdData_reg <= rdData_next;
      rdValid_reg <= sfrRdStb;
      pinOut_reg <= pinOut_next;
      pinOeN_reg <= pinOeN_next;
    end
  end

  // Outputs come straight from flops so pins never glitch on decode
  assign sfrRdData = rdData_reg;
  assign sfrRdValid = rdValid_reg;
  assign pinOut = pinOut_reg;
  assign pinOeN = pinOeN_reg;

  // Latch write lands at the next edge
  AST_LATCH_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    wrLatch |=> latch_reg == $past(sfrWrData[PORT_W-1:0]))
    else $error("output latch did not take written value");

  // Push-pull pin shows written data right after the write
  AST_WRITE_TO_PIN: assert property (@(posedge clk) disable iff (sys_rst)
    wrLatch && (&driveSel_reg) && !wrSelect |=>
      pinOut == ($past(sfrWrData[PORT_W-1:0]) & $past(periphOut)) && pinOeN == '0)
    else $error("pin did not follow latch write");

  // Readback returns the pins seen in the strobe cycle
  AST_PIN_SAMPLE: assert property (@(posedge clk) disable iff (sys_rst)
    sfrRdStb && hitReadback |=> sfrRdData == 8'($past(pinIn)) && sfrRdValid)
    else $error("readback did not return sampled pins");

  // Latch read returns stored latch
  AST_LATCH_READ: assert property (@(posedge clk) disable iff (sys_rst)
    sfrRdStb && hitLatch |=> sfrRdData == 8'($past(latch_reg)))
    else $error("latch read returned wrong data");

  // Values after reset release
  AST_RESET_VALUES: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> latch_reg == PORT_W'(pgp_pkg::RST_OUTPUT_LATCH)
      && driveSel_reg == '0 && pinOeN == '1)
    else $error("reset values wrong");

  // Writes to the readback address change nothing
  AST_READBACK_RO: assert property (@(posedge clk) disable iff (sys_rst)
    sfrWrStb && hitReadback |=> $stable(latch_reg) && $stable(driveSel_reg))
    else $error("write to readback altered state");

  // Push-pull bits never float
  AST_PUSH_PULL: assert property (@(posedge clk) disable iff (sys_rst)
    $stable(driveSel_reg) && (&driveSel_reg) && !$past(sys_rst) |-> pinOeN == '0)
    else $error("push-pull pin left undriven");

  // Open drain floats only when latch and peripheral are both high
  AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && ~|driveSel_reg && $stable(driveSel_reg) && $stable(latch_reg)
      |-> pinOeN == ($past(latch_reg) & $past(periphOut)) && pinOut == '0)
    else $error("open drain level wrong");

  // Addresses outside the block read as zero
  AST_UNMAPPED: assert property (@(posedge clk) disable iff (sys_rst)
    sfrRdStb && !hitLatch && !hitSelect && !hitReadback |=>
      sfrRdData == pgp_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");

  // Checks below watch the storage, the read path and the pin stage.
  // Pin outputs lag periphOut by one edge, so pin checks use its past value.
  // Checks right after reset release are guarded: the pin flops still show
  // their reset values for one edge.

  // Drive select write lands at the next edge
  AST_SELECT_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    wrSelect |=> driveSel_reg == $past(sfrWrData[PORT_W-1:0]))
    else $error("drive select did not take written value");

  // Latch keeps its value when not written
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !wrLatch |=> $stable(latch_reg))
    else $error("output latch changed without write");

  // Drive select keeps its value when not written
  AST_SELECT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !wrSelect |=> $stable(driveSel_reg))
    else $error("drive select changed without write");

  // Every read strobe is answered one edge later
  AST_VALID_AFTER_READ: assert property (@(posedge clk) disable iff (sys_rst)
    sfrRdStb |=> sfrRdValid)
    else $error("read not answered");

  // No answer without a read strobe
  AST_VALID_NO_READ: assert property (@(posedge clk) disable iff (sys_rst)
    !sfrRdStb |=> !sfrRdValid)
    else $error("read valid without strobe");

  // Valid always traces back to a strobe
  AST_VALID_SOURCE: assert property (@(posedge clk) disable iff (sys_rst)
    sfrRdValid |-> $past(sfrRdStb))
    else $error("read valid has no source strobe");

  // Read data holds until the next read
  AST_RDDATA_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !sfrRdStb |=> $stable(sfrRdData))
    else $error("read data moved without read");

  // Drive select read returns the stored select
  AST_SELECT_READ: assert property (@(posedge clk) disable iff (sys_rst)
    sfrRdStb && hitSelect |=> sfrRdData == 8'($past(driveSel_reg)))
    else $error("drive select read returned wrong data");

  // Pin level follows select, latch and peripheral
  AST_PIN_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> pinOut == (driveSel_reg & latch_reg & $past(periphOut)))
    else $error("pin level wrong");

  // Pin enable follows select, latch and peripheral
  AST_PIN_ENABLE: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> pinOeN == (~driveSel_reg & latch_reg & $past(periphOut)))
    else $error("pin enable wrong");

  // A floating pin never carries a high drive level
  AST_NO_HIGH_WHILE_FLOAT: assert property (@(posedge clk) disable iff (sys_rst)
    (pinOut & pinOeN) == '0)
    else $error("high level on floating pin");

  // Latch write leaves drive select alone
  AST_LATCH_WRITE_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
    wrLatch |=> $stable(driveSel_reg))
    else $error("latch write altered drive select");

  // Drive select write leaves the latch alone
  AST_SELECT_WRITE_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
    wrSelect |=> $stable(latch_reg))
    else $error("drive select write altered latch");

  // Reads have no side effect on storage
  AST_READ_NO_EFFECT: assert property (@(posedge clk) disable iff (sys_rst)
    sfrRdStb && !sfrWrStb |=> $stable(latch_reg) && $stable(driveSel_reg))
    else $error("read altered storage");

  // Writes outside the block change nothing
  AST_UNMAPPED_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    sfrWrStb && !hitLatch && !hitSelect |=> $stable(latch_reg) && $stable(driveSel_reg))
    else $error("foreign write altered storage");

  // Bits above the port width read as zero
  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    sfrRdStb |=> (sfrRdData >> PORT_W) == 8'h00)
    else $error("bits above port width not zero");

  // Pins stay put while nothing that feeds them moves
  AST_PIN_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    $stable(latch_reg) && $stable(driveSel_reg) && $past(periphOut) == $past(periphOut, 2)
      && !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(pinOut) && $stable(pinOeN))
    else $error("pins moved with steady inputs");

  // Open-drain bit with latch low is pulled low
  AST_OD_SINK: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> ((~driveSel_reg & ~latch_reg) & pinOeN) == '0)
    else $error("open drain low bit left floating");

  // Push-pull bits are always driven
  AST_PP_DRIVEN: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (driveSel_reg & pinOeN) == '0)
    else $error("push-pull bit floating");

  // A latch bit at zero never shows high
  AST_LATCH_ZERO_LOW: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (~latch_reg & pinOut) == '0)
    else $error("zero latch bit shows high");

  // Peripheral low pulls its pin whatever the mode
  AST_PERIPH_GATE: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (~$past(periphOut) & (pinOut | pinOeN)) == '0)
    else $error("peripheral low did not pull pin");

  // Write to readback leaves read data alone
  AST_READBACK_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    sfrWrStb && hitReadback && !sfrRdStb |=> $stable(sfrRdData))
    else $error("write to readback moved read data");

  // Open-drain pins follow a latch write at once
  AST_WRITE_TO_OD: assert property (@(posedge clk) disable iff (sys_rst)
    wrLatch && ~|driveSel_reg && !wrSelect |=>
      pinOeN == ($past(sfrWrData[PORT_W-1:0]) & $past(periphOut)) && pinOut == '0)
    else $error("open drain pin did not follow latch write");

  // Drive select write switches the stage at once
  AST_SELECT_TO_PIN: assert property (@(posedge clk) disable iff (sys_rst)
    wrSelect && !wrLatch |=>
      pinOeN == (~$past(sfrWrData[PORT_W-1:0]) & $past(latch_reg) & $past(periphOut)))
    else $error("pin stage did not follow select write");

  // Unmapped reads are still answered
  AST_UNMAPPED_VALID: assert property (@(posedge clk) disable iff (sys_rst)
    sfrRdStb && !hitLatch && !hitSelect && !hitReadback |=> sfrRdValid)
    else $error("unmapped read not answered");

  // Read path and pin level show reset values at release
  AST_RESET_OUTPUTS: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> pinOut == '0 && !sfrRdValid && sfrRdData == pgp_pkg::RST_READ_DATA)
    else $error("outputs not at reset values");

endmodule

// >>> dv/pgp_board.sv
// Board model for port 0: pull-up on every pin plus an open-drain sink.
// Assumes pinOeN low means the block drives pinOut onto the pin.
`timescale 1ns/1ps
module pgp_board
(
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOeN,
  input wire logic [7:0] extLow,
  output logic [7:0] pinIn
);
  // Floating pins rise through the pull-up unless the board sinks them
  assign pinIn = (~pinOeN & pinOut) | (pinOeN & ~extLow);
endmodule

// >>> dv/pgp_port0_tb.sv
// Self-checking bench for the port 0 pin block.
// Assumes pgp_pkg is compiled first and pgp_board resolves the pins.
`timescale 1ns/1ps
module pgp_port0_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] sfrAddr = 6'h00;
  logic sfrRdStb = 1'b0;
  logic sfrWrStb = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic [7:0] periphOut = 8'hff;
  logic [7:0] extLow = 8'h00;
  logic [7:0] sfrRdData, pinOut, pinOeN, pinIn, lat, sel, d;
  logic sfrRdValid;
  integer seed = 26447;
  int bad_count = 0;
  int n_tests = 0;

  pgp_port0 pgp_port0_inst (.clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr),
    .sfrRdStb(sfrRdStb), .sfrWrStb(sfrWrStb), .sfrWrData(sfrWrData),
    .sfrRdData(sfrRdData), .sfrRdValid(sfrRdValid), .pinIn(pinIn),
    .periphOut(periphOut), .pinOut(pinOut), .pinOeN(pinOeN));
  pgp_board pgp_board_inst (.pinOut(pinOut), .pinOeN(pinOeN), .extLow(extLow),
    .pinIn(pinIn));

  // 20 MHz clock
  initial forever #25 clk = ~clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle strobes; data taken one edge after the read strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    @(posedge clk) #1;
    sfrAddr = a;
    sfrRdStb = 1'b1;
    @(posedge clk) #1;
    sfrRdStb = 1'b0;
    chk({7'h00, sfrRdValid}, 8'h01);
    q = sfrRdData;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk) #1;
    sfrAddr = a;
    sfrWrData = v;
    sfrWrStb = 1'b1;
    @(posedge clk) #1;
    sfrWrStb = 1'b0;
  endtask

  // Open drain floats only when latch and peripheral are both high
  function automatic logic [7:0] expPin(input logic [7:0] l, s, p, e);
    return l & p & ~(e & ~s);
  endfunction

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reset values, unmapped read, then random port settings
  initial
  begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(pgp_pkg::OFS_OUTPUT_LATCH, d);
    chk(d, 8'hff);
    rd(pgp_pkg::OFS_DRIVE_SELECT, d);
    chk(d, 8'h00);
    chk(pinOeN, 8'hff);
    rd(6'h3f, d);
    chk(d, pgp_pkg::UNMAPPED_READ);
    for (int i = 0; i < 60; i++)
    begin
      lat = (i == 0) ? 8'h00 : 8'($random(seed));
      sel = (i == 1) ? 8'hff : 8'($random(seed));
      periphOut = (i < 2) ? 8'hff : 8'($random(seed));
      extLow = 8'($random(seed)) & ~sel;
      wr(pgp_pkg::OFS_OUTPUT_LATCH, lat);
      wr(pgp_pkg::OFS_DRIVE_SELECT, sel);
      chk(pinOut, sel & lat & periphOut);
      chk(pinOeN, ~sel & lat & periphOut);
      wr(pgp_pkg::OFS_PIN_READBACK, ~lat);
      rd(pgp_pkg::OFS_OUTPUT_LATCH, d);
      chk(d, lat);
      rd(pgp_pkg::OFS_DRIVE_SELECT, d);
      chk(d, sel);
      rd(pgp_pkg::OFS_PIN_READBACK, d);
      chk(d, expPin(lat, sel, periphOut, extLow));
      chk(pinOut, sel & lat & periphOut);
    end
    // Peripheral output passes while the latch bits stay high
    wr(pgp_pkg::OFS_OUTPUT_LATCH, 8'hff);
    wr(pgp_pkg::OFS_DRIVE_SELECT, 8'hff);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk) #1;
      periphOut = 8'($random(seed));
      @(posedge clk) #1;
      chk(pinOut, periphOut);
      chk(pinOeN, 8'h00);
    end
    // Mid-run reset must restore latch and drive select
    wr(pgp_pkg::OFS_OUTPUT_LATCH, 8'h5a);
    @(posedge clk) #1;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(pgp_pkg::OFS_OUTPUT_LATCH, d);
    chk(d, 8'hff);
    rd(pgp_pkg::OFS_DRIVE_SELECT, d);
    chk(d, 8'h00);
    chk(pinOeN, periphOut);
    finish_test;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #(50 * 5000);
    bad_count++;
    finish_test;
  end
endmodule
